// >>> core/ppgt_pkg.sv
// Constants, register map and types of the optical pulse timing block
package ppgt_pkg;

  // ***********************************************
  // Widths and sizes
  // ***********************************************
  localparam int DIV_W = 14;
  localparam int ADC_W = 16;
  localparam int SMP_W = 24;
  localparam int NBUF = 4;
  localparam int NOPT = 2;
  localparam int NSLOT = 4;
  localparam int FIFO_DEPTH = 16;
  localparam int THR_W = 5;
  localparam int CUR_W = 3;
  localparam int FINE_W = 8;
  localparam int AMB_W = 3;
  localparam int TIA_W = 4;
  localparam int GAIN_W = 3;
  localparam int EVT_W = 3 * NBUF;
  localparam int ADDR_W = 8;

  // ***********************************************
  // Register pages and offsets
  // ***********************************************
  localparam logic PAGE_MAIN = 1'b0;
  localparam logic PAGE_TIMING = 1'b1;
  localparam logic [ADDR_W-1:0] OFF_IRQ_EN = 8'h4c;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 8'h54;
  localparam logic [ADDR_W-1:0] OFF_TC10 = 8'h50;
  localparam logic [ADDR_W-1:0] OFF_TC11 = 8'h54;
  localparam logic [ADDR_W-1:0] OFF_TC12 = 8'h58;
  localparam logic [ADDR_W-1:0] OFF_TC13 = 8'h5c;
  localparam logic [ADDR_W-1:0] OFF_TC14 = 8'h60;
  localparam logic [ADDR_W-1:0] OFF_TC15 = 8'h64;
  localparam logic [ADDR_W-1:0] OFF_TC16 = 8'h68;
  localparam logic [ADDR_W-1:0] OFF_TC17 = 8'h6c;
  localparam logic [ADDR_W-1:0] OFF_TC18 = 8'h70;

  // ***********************************************
  // Field positions
  // ***********************************************
  localparam int F_EN = 0;
  localparam int F_PD = 1;
  localparam int F_HB = 2;
  localparam int F_DIV = 16;
  localparam int F_CUR_A = 0;
  localparam int F_CUR_B = 4;
  localparam int F_FINE_A = 8;
  localparam int F_FINE_B = 16;
  localparam int F_AMB_E = 0;
  localparam int F_AMB_A = 4;
  localparam int F_TIA = 0;
  localparam int F_GAIN = 8;
  localparam int F_THR_A = 0;
  localparam int F_THR_B = 8;

  // ***********************************************
  // Timing and values
  // ***********************************************
  localparam int REF_HZ = 1000000;
  localparam int MIN_RX_US = 50;
  localparam int MIN_RX_TICKS = (MIN_RX_US * REF_HZ + 999999) / 1000000;
  localparam logic [31:0] RST_TC10 = 32'h3d08_0000;
  localparam logic [31:0] RST_TC11 = 32'h0000_00eb;
  localparam logic [31:0] RST_TC12 = 32'(MIN_RX_TICKS);
  localparam logic [AMB_W-1:0] AMB_MAX = 3'h6;
  localparam logic [GAIN_W-1:0] GAIN_MAX = 3'h5;
  localparam logic [SMP_W-1:0] POS_FS = 24'h03ffff;
  localparam logic [SMP_W-1:0] NEG_FS = 24'h400000;
  localparam int SIGN_BIT = 22;
  localparam int ADC_SHIFT = 2;

  typedef enum logic [2:0] {
    SLOT_IDLE,
    SLOT_E1,
    SLOT_A1,
    SLOT_E2,
    SLOT_A2
  } ppgt_slot_t;

endpackage

// >>> core/ppgt_timing.sv
// Pulse timing, sample formatting, buffers and event flags of the channel
`timescale 1ns/1ns

// Sample buffer with valid/ready on both sides
module ppgt_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o,
  // Fill level
  output logic [$clog2(DEPTH):0] level_o
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } ppgt_fifo_st_t;

  ppgt_fifo_st_t s_q;
  ppgt_fifo_st_t s_d;
  logic push;
  logic pop;

  assign in_ready_o = (s_q.cnt != (AW+1)'(DEPTH));
  assign out_valid_o = (s_q.cnt != '0);
  assign out_data_o = s_q.mem[s_q.rp];
  assign level_o = s_q.cnt;
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;

  always_comb
  begin
    s_d = s_q;
    if (push)
    begin
      s_d.mem[s_q.wp] = in_data_i;
      s_d.wp = s_q.wp + AW'(1);
    end
    if (pop)
    begin
      s_d.rp = s_q.rp + AW'(1);
    end
    if (push && !pop)
    begin
      s_d.cnt = s_q.cnt + (AW+1)'(1);
    end
    else if (pop && !push)
    begin
      s_d.cnt = s_q.cnt - (AW+1)'(1);
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end
endmodule

// Overview of operation
// - Per-event interrupt enable register
// - Status register records interrupt cause
// - Threshold event per each of four buffers
// - Three-bit LED full-scale current code
// - Push-pull or H-bridge drive selectable
// - Ambient cancel settings, emitter and ambient, seven steps
// - Transimpedance low-pass tuning setting held
// - Six receive gain choices via field
// - Each phase converted by 16-bit converter
// - Optical sample is 23-bit two's complement in a 24-bit word
// - Sign at bit 22, fixed full-scale codes
// - Saturate at full scale, never wrap
// - Power down front end while LEDs off and no hold window open
// - Rate from divider on 1 MHz reference
// - LED on-time sets duty within period
// - Four slots: emitter, ambient, emitter, ambient
// - Emitter slot sampled only while LED lit
// - Ambient slots sampled between LED pulses
// - Enable at 0x4C, status at 0x54
module ppgt_timing (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // 1 MHz timing reference, asynchronous
  input wire logic ref_clk_i,
  // Register port behind the serial interface
  input wire logic reg_page_i,
  input wire logic [ppgt_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [31:0] reg_wdata_i,
  output logic [31:0] reg_rdata_o,
  // Interrupt request
  output logic irq_o,
  // Emitter and front end control
  output logic [1:0] led_on_o,
  output logic hbridge_o,
  output logic afe_pd_o,
  output logic [ppgt_pkg::NSLOT-1:0] sample_hold_o,
  output logic [ppgt_pkg::CUR_W-1:0] led_cur_a_o,
  output logic [ppgt_pkg::CUR_W-1:0] led_cur_b_o,
  output logic [ppgt_pkg::FINE_W-1:0] led_fine_a_o,
  output logic [ppgt_pkg::FINE_W-1:0] led_fine_b_o,
  output logic [ppgt_pkg::AMB_W-1:0] amb_cancel_emit_o,
  output logic [ppgt_pkg::AMB_W-1:0] amb_cancel_idle_o,
  output logic [ppgt_pkg::TIA_W-1:0] transimpedance_lowpass_setting_o,
  output logic [ppgt_pkg::GAIN_W-1:0] receive_gain_setting_o,
  // Converter
  output logic conv_start_o,
  output logic [1:0] conv_slot_o,
  input wire logic adc_valid_i,
  output logic adc_ready_o,
  input wire logic [ppgt_pkg::ADC_W-1:0] adc_data_i,
  input wire logic adc_ovr_i,
  // Optical sample streams, index 0 first emitter, 1 second
  output logic [ppgt_pkg::NOPT-1:0] smp_valid_o,
  input wire logic [ppgt_pkg::NOPT-1:0] smp_ready_i,
  output logic [ppgt_pkg::NOPT-1:0][ppgt_pkg::SMP_W-1:0] smp_data_o,
  // Cardiac and beat interval buffer levels, index 0 cardiac
  input wire logic [1:0] ext_thr_i,
  input wire logic [1:0] ext_full_i,
  input wire logic [1:0] ext_empty_i
);

  // ***********************************************
  // State
  // ***********************************************
  typedef struct packed {
    logic ref_s1;
    logic ref_s2;
    logic ref_s3;
    logic [ppgt_pkg::EVT_W-1:0] irq_en;
    logic [ppgt_pkg::EVT_W-1:0] irq_stat;
    logic [31:0] tc10;
    logic [31:0] tc11;
    logic [31:0] tc12;
    logic [31:0] tc13;
    logic [31:0] tc14;
    logic [31:0] tc15;
    logic [31:0] tc16;
    logic [1:0][ppgt_pkg::SMP_W-1:0] amb;
    ppgt_pkg::ppgt_slot_t slot;
    logic [ppgt_pkg::DIV_W-1:0] cnt;
    logic [ppgt_pkg::DIV_W-1:0] stick;
    logic [ppgt_pkg::NSLOT-1:0] hold;
    logic [1:0] led;
    logic pd;
    logic conv;
    logic [1:0] conv_slot;
    logic [31:0] rdata;
  } ppgt_state_t;

  ppgt_state_t s_q;
  ppgt_state_t s_d;

  logic [ppgt_pkg::NOPT-1:0] f_in_valid;
  logic [ppgt_pkg::NOPT-1:0] f_in_ready;
  logic [ppgt_pkg::NOPT-1:0][4:0] f_level;
  logic [ppgt_pkg::NBUF-1:0] b_thr;
  logic [ppgt_pkg::NBUF-1:0] b_full;
  logic [ppgt_pkg::NBUF-1:0] b_empty;
  logic [ppgt_pkg::EVT_W-1:0] evt;
  logic [ppgt_pkg::NOPT-1:0][ppgt_pkg::THR_W-1:0] thr;
  logic [ppgt_pkg::SMP_W-1:0] word;
  logic [22:0] ext;
  logic res_emit;
  logic res_ch;

  // ***********************************************
  // Sample formatting
  // ***********************************************
  always_comb
  begin
    ext = 23'(signed'(adc_data_i)) <<< ppgt_pkg::ADC_SHIFT;
    if (adc_ovr_i)
    begin
      // Overrange clips to full scale in the input's direction
      word = adc_data_i[ppgt_pkg::ADC_W-1] ? ppgt_pkg::NEG_FS
                                            : ppgt_pkg::POS_FS;
    end
    else
    begin
      word = {1'b0, ext};
    end
  end

  // Converter returns results in the order conversions were started
  assign res_emit = (s_q.conv_slot == 2'h0) || (s_q.conv_slot == 2'h2);
  assign res_ch = s_q.conv_slot[1];
  assign thr[0] = s_q.tc16[ppgt_pkg::F_THR_A +: ppgt_pkg::THR_W];
  assign thr[1] = s_q.tc16[ppgt_pkg::F_THR_B +: ppgt_pkg::THR_W];
  // A full buffer stalls the converter rather than dropping samples
  assign adc_ready_o = res_emit ? f_in_ready[res_ch] : 1'b1;

  // ***********************************************
  // Optical buffers
  // ***********************************************
  genvar gi;
  generate
    for (gi = 0; gi < ppgt_pkg::NOPT; gi++)
    begin : g_opt
      assign f_in_valid[gi] = adc_valid_i && res_emit && (res_ch == gi);
      ppgt_fifo #(
        .WIDTH(ppgt_pkg::SMP_W),
        .DEPTH(ppgt_pkg::FIFO_DEPTH)
      ) u_fifo (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .in_valid_i(f_in_valid[gi]),
        .in_ready_o(f_in_ready[gi]),
        .in_data_i(word),
        .out_valid_o(smp_valid_o[gi]),
        .out_ready_i(smp_ready_i[gi]),
        .out_data_o(smp_data_o[gi]),
        .level_o(f_level[gi])
      );
      assign b_thr[gi+1] = (thr[gi] != '0) && (f_level[gi] >= thr[gi]);
      assign b_full[gi+1] = !f_in_ready[gi];
      assign b_empty[gi+1] = (f_level[gi] == '0);
    end
    for (gi = 0; gi < ppgt_pkg::NBUF; gi++)
    begin : g_evt
      // Three flags per buffer: threshold, full, empty
      assign evt[3*gi] = b_thr[gi];
      assign evt[3*gi+1] = b_full[gi];
      assign evt[3*gi+2] = b_empty[gi];
    end
  endgenerate

  assign b_thr[0] = ext_thr_i[0];
  assign b_thr[3] = ext_thr_i[1];
  assign b_full[0] = ext_full_i[0];
  assign b_full[3] = ext_full_i[1];
  assign b_empty[0] = ext_empty_i[0];
  assign b_empty[3] = ext_empty_i[1];

  // ***********************************************
  // Next state
  // ***********************************************
  logic tick;
  logic en;
  logic lit1;
  logic lit2;
  logic [ppgt_pkg::DIV_W-1:0] div;
  logic [ppgt_pkg::DIV_W-1:0] on_t;
  logic [ppgt_pkg::DIV_W-1:0] win;
  logic [ppgt_pkg::DIV_W-1:0] q1;
  logic [ppgt_pkg::DIV_W-1:0] q2;
  logic [ppgt_pkg::DIV_W-1:0] q3;
  logic [ppgt_pkg::NSLOT-1:0] h;
  logic [ppgt_pkg::NSLOT-1:0] fall;
  logic [ppgt_pkg::EVT_W-1:0] clr;
  logic mw;
  logic tw;

  always_comb
  begin
    s_d = s_q;
    s_d.ref_s1 = ref_clk_i;
    s_d.ref_s2 = s_q.ref_s1;
    s_d.ref_s3 = s_q.ref_s2;
    tick = s_q.ref_s2 & ~s_q.ref_s3;
    en = s_q.tc10[ppgt_pkg::F_EN];
    div = s_q.tc10[ppgt_pkg::F_DIV +: ppgt_pkg::DIV_W];
    on_t = s_q.tc11[ppgt_pkg::DIV_W-1:0];
    win = s_q.tc12[ppgt_pkg::DIV_W-1:0];
    q1 = div >> 2;
    q2 = div >> 1;
    q3 = ppgt_pkg::DIV_W'(q1 + q2);

    // Period and slot sequencer, one step per rising reference edge
    if (!en)
    begin
      s_d.slot = ppgt_pkg::SLOT_IDLE;
      s_d.cnt = '0;
      s_d.stick = '0;
    end
    else if (tick)
    begin
      s_d.cnt = s_q.cnt + ppgt_pkg::DIV_W'(1);
      s_d.stick = s_q.stick + ppgt_pkg::DIV_W'(1);
      if (s_q.slot == ppgt_pkg::SLOT_IDLE || s_q.cnt >= div)
      begin
        // Period is divider plus one reference ticks
        s_d.cnt = '0;
        s_d.stick = '0;
        s_d.slot = ppgt_pkg::SLOT_E1;
      end
      else
      begin
        case (s_q.slot)
          ppgt_pkg::SLOT_E1:
          begin
            if (s_d.cnt == q1)
            begin
              s_d.slot = ppgt_pkg::SLOT_A1;
              s_d.stick = '0;
            end
          end
          ppgt_pkg::SLOT_A1:
          begin
            if (s_d.cnt == q2)
            begin
              s_d.slot = ppgt_pkg::SLOT_E2;
              s_d.stick = '0;
            end
          end
          ppgt_pkg::SLOT_E2:
          begin
            if (s_d.cnt == q3)
            begin
              s_d.slot = ppgt_pkg::SLOT_A2;
              s_d.stick = '0;
            end
          end
          default:
          begin
            s_d.slot = s_q.slot;
          end
        endcase
      end
    end

    // LED lit for the programmed on-time at the start of its slot
    lit1 = (s_d.slot == ppgt_pkg::SLOT_E1) && (s_d.stick < on_t);
    lit2 = (s_d.slot == ppgt_pkg::SLOT_E2) && (s_d.stick < on_t);
    s_d.led = {lit2, lit1};
    h[0] = lit1 && (s_d.stick < win);
    h[1] = (s_d.slot == ppgt_pkg::SLOT_A1) && (s_d.stick < win);
    h[2] = lit2 && (s_d.stick < win);
    h[3] = (s_d.slot == ppgt_pkg::SLOT_A2) && (s_d.stick < win);
    s_d.hold = h;
    // Ambient windows keep the front end awake even with LEDs dark
    s_d.pd = !en || (s_q.tc10[ppgt_pkg::F_PD] && !lit1 && !lit2
                     && (h == '0));

    // End of a hold window starts one conversion for that slot
    fall = s_q.hold & ~h;
    s_d.conv = (fall != '0);
    for (int i = 0; i < ppgt_pkg::NSLOT; i++)
    begin
      if (fall[i])
      begin
        s_d.conv_slot = 2'(i);
      end
    end

    // Ambient results kept for software
    if (adc_valid_i && !res_emit)
    begin
      s_d.amb[res_ch] = word;
    end

    // Register writes
    mw = reg_wr_i && (reg_page_i == ppgt_pkg::PAGE_MAIN);
    tw = reg_wr_i && (reg_page_i == ppgt_pkg::PAGE_TIMING);
    clr = '0;
    if (mw && reg_addr_i == ppgt_pkg::OFF_IRQ_EN)
    begin
      s_d.irq_en = reg_wdata_i[ppgt_pkg::EVT_W-1:0];
    end
    if (mw && reg_addr_i == ppgt_pkg::OFF_IRQ_STAT)
    begin
      clr = reg_wdata_i[ppgt_pkg::EVT_W-1:0];
    end
    if (tw)
    begin
      case (reg_addr_i)
        ppgt_pkg::OFF_TC10: s_d.tc10 = reg_wdata_i;
        ppgt_pkg::OFF_TC11: s_d.tc11 = reg_wdata_i;
        ppgt_pkg::OFF_TC12: s_d.tc12 = reg_wdata_i;
        ppgt_pkg::OFF_TC13: s_d.tc13 = reg_wdata_i;
        ppgt_pkg::OFF_TC14: s_d.tc14 = reg_wdata_i;
        ppgt_pkg::OFF_TC15: s_d.tc15 = reg_wdata_i;
        ppgt_pkg::OFF_TC16: s_d.tc16 = reg_wdata_i;
        default: s_d.tc10 = s_q.tc10;
      endcase
    end
    // Write-one clears, a new event in the same cycle wins
    s_d.irq_stat = (s_q.irq_stat & ~clr) | evt;

    // Register reads, unmapped addresses read zero
    s_d.rdata = '0;
    if (reg_rd_i && reg_page_i == ppgt_pkg::PAGE_MAIN)
    begin
      case (reg_addr_i)
        ppgt_pkg::OFF_IRQ_EN: s_d.rdata = 32'(s_q.irq_en);
        ppgt_pkg::OFF_IRQ_STAT: s_d.rdata = 32'(s_q.irq_stat);
        default: s_d.rdata = '0;
      endcase
    end
    else if (reg_rd_i)
    begin
      case (reg_addr_i)
        ppgt_pkg::OFF_TC10: s_d.rdata = s_q.tc10;
        ppgt_pkg::OFF_TC11: s_d.rdata = s_q.tc11;
        ppgt_pkg::OFF_TC12: s_d.rdata = s_q.tc12;
        ppgt_pkg::OFF_TC13: s_d.rdata = s_q.tc13;
        ppgt_pkg::OFF_TC14: s_d.rdata = s_q.tc14;
        ppgt_pkg::OFF_TC15: s_d.rdata = s_q.tc15;
        ppgt_pkg::OFF_TC16: s_d.rdata = s_q.tc16;
        ppgt_pkg::OFF_TC17: s_d.rdata = 32'(s_q.amb[0]);
        ppgt_pkg::OFF_TC18: s_d.rdata = 32'(s_q.amb[1]);
        default: s_d.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      s_q <= '0;
      s_q.slot <= ppgt_pkg::SLOT_IDLE;
      s_q.tc10 <= ppgt_pkg::RST_TC10;
      s_q.tc11 <= ppgt_pkg::RST_TC11;
      s_q.tc12 <= ppgt_pkg::RST_TC12;
      s_q.pd <= 1'b1;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ***********************************************
  // Outputs
  // ***********************************************
  logic [ppgt_pkg::AMB_W-1:0] amb_e;
  logic [ppgt_pkg::AMB_W-1:0] amb_a;
  logic [ppgt_pkg::GAIN_W-1:0] gain;

  assign amb_e = s_q.tc14[ppgt_pkg::F_AMB_E +: ppgt_pkg::AMB_W];
  assign amb_a = s_q.tc14[ppgt_pkg::F_AMB_A +: ppgt_pkg::AMB_W];
  assign gain = s_q.tc15[ppgt_pkg::F_GAIN +: ppgt_pkg::GAIN_W];
  // Codes beyond the last step hold at the top step
  assign amb_cancel_emit_o = (amb_e > ppgt_pkg::AMB_MAX) ? ppgt_pkg::AMB_MAX
                                                         : amb_e;
  assign amb_cancel_idle_o = (amb_a > ppgt_pkg::AMB_MAX) ? ppgt_pkg::AMB_MAX
                                                         : amb_a;
  assign receive_gain_setting_o = (gain > ppgt_pkg::GAIN_MAX)
                                  ? ppgt_pkg::GAIN_MAX : gain;
  assign transimpedance_lowpass_setting_o =
    s_q.tc15[ppgt_pkg::F_TIA +: ppgt_pkg::TIA_W];
  assign led_cur_a_o =
    s_q.tc13[ppgt_pkg::F_CUR_A +: ppgt_pkg::CUR_W];
  assign led_cur_b_o =
    s_q.tc13[ppgt_pkg::F_CUR_B +: ppgt_pkg::CUR_W];
  assign led_fine_a_o = s_q.tc13[ppgt_pkg::F_FINE_A +: ppgt_pkg::FINE_W];
  assign led_fine_b_o = s_q.tc13[ppgt_pkg::F_FINE_B +: ppgt_pkg::FINE_W];
  assign hbridge_o = s_q.tc10[ppgt_pkg::F_HB];
  assign led_on_o = s_q.led;
  assign afe_pd_o = s_q.pd;
  assign sample_hold_o = s_q.hold;
  assign conv_start_o = s_q.conv;
  assign conv_slot_o = s_q.conv_slot;
  assign reg_rdata_o = s_q.rdata;
  assign irq_o = |(s_q.irq_stat & s_q.irq_en);
endmodule

// >>> tb/ppgt_timing_asserts.sv
// Port assertions of the pulse timing block
`timescale 1ns/1ns
module ppgt_timing_chk (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Register port
  input wire logic reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  // Front end
  input wire logic [1:0] led_on_o,
  input wire logic afe_pd_o,
  input wire logic [ppgt_pkg::NSLOT-1:0] sample_hold_o,
  input wire logic [ppgt_pkg::AMB_W-1:0] amb_cancel_emit_o,
  input wire logic [ppgt_pkg::AMB_W-1:0] amb_cancel_idle_o,
  input wire logic [ppgt_pkg::GAIN_W-1:0] receive_gain_setting_o,
  // Converter and streams
  input wire logic conv_start_o,
  input wire logic [1:0] conv_slot_o,
  input wire logic [ppgt_pkg::NOPT-1:0] smp_valid_o,
  input wire logic [ppgt_pkg::NOPT-1:0] smp_ready_i,
  input wire logic [ppgt_pkg::NOPT-1:0][ppgt_pkg::SMP_W-1:0] smp_data_o
);
  // ****
  // Slot order tracking
  // ****
  logic seen_q;
  logic [1:0] slot_q;
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      seen_q <= 1'b0;
      slot_q <= 2'h0;
    end
    else if (conv_start_o)
    begin
      seen_q <= 1'b1;
      slot_q <= conv_slot_o;
    end
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);
  // ****
  // Properties
  // ****
  AST_RDATA_IDLE: assert property (
    !$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
    else $error("read data not zero outside a read");
  AST_LED_ONE: assert property (led_on_o != 2'b11)
    else $error("both emitters lit");
  AST_PD_LIT: assert property (|led_on_o |-> !afe_pd_o)
    else $error("front end down while lit");
  AST_HOLD_ONE: assert property ($onehot0(sample_hold_o))
    else $error("two hold windows at once");
  AST_EMIT_LIT: assert property (
    sample_hold_o[0] || sample_hold_o[2] |->
    led_on_o == {sample_hold_o[2], sample_hold_o[0]})
    else $error("emitter hold without its LED");
  AST_AMB_DARK: assert property (
    sample_hold_o[1] || sample_hold_o[3] |->
    led_on_o == 2'b00)
    else $error("ambient hold while lit");
  AST_GAIN_CAP: assert property (receive_gain_setting_o <= 3'h5)
    else $error("gain beyond last choice");
  AST_AMB_CAP: assert property (amb_cancel_emit_o <= 3'h6 &&
    amb_cancel_idle_o <= 3'h6)
    else $error("ambient cancel beyond six");
  AST_CONV_PULSE: assert property (conv_start_o |=> !conv_start_o)
    else $error("conversion start too long");
  AST_SLOT_SEQ: assert property (conv_start_o && seen_q |->
    conv_slot_o == slot_q + 2'h1)
    else $error("slot out of order");
  AST_STREAM_HOLD: assert property (
    smp_valid_o[0] && !smp_ready_i[0] |=>
    smp_valid_o[0] && $stable(smp_data_o[0]))
    else $error("stream word dropped");
  AST_WORD_TOP: assert property (
    smp_valid_o[1] |-> !smp_data_o[1][23])
    else $error("bit above sign set");
endmodule

bind ppgt_timing ppgt_timing_chk ppgt_timing_chk_i (.clk_i, .rst_b_i,
  .reg_rd_i, .reg_rdata_o, .led_on_o, .afe_pd_o, .sample_hold_o,
  .amb_cancel_emit_o, .amb_cancel_idle_o, .receive_gain_setting_o,
  .conv_start_o, .conv_slot_o, .smp_valid_o, .smp_ready_i, .smp_data_o);

// >>> tb/ppgt_adc_model.sv
// Behavioural converter answering the block's conversion starts
`timescale 1ns/1ns
module ppgt_adc_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Conversion request
  input wire logic conv_start_i,
  input wire logic [1:0] conv_slot_i,
  input wire logic [31:0] rnd_i,
  // Result handshake
  output logic adc_valid_o,
  input wire logic adc_ready_i,
  output logic [15:0] adc_data_o,
  output logic adc_ovr_o
);
  logic [23:0] exp0_q[$];
  logic [23:0] exp1_q[$];
  logic [1:0] slot;
  logic [23:0] w;
  initial
  begin
    adc_valid_o = 1'b0;
    adc_data_o = 16'h0;
    adc_ovr_o = 1'b0;
    forever
    begin
      @(posedge clk_i);
      if (rst_b_i && conv_start_i)
      begin
        slot = conv_slot_i;
        // Varying latency: prompt and slow answers
        repeat (1 + rnd_i[2:0]) @(posedge clk_i);
        #2;
        adc_data_o = rnd_i[17:16] == 2'h0 ? {rnd_i[31], {15{!rnd_i[31]}}}
          : rnd_i[15:0];
        adc_ovr_o = rnd_i[20:18] == 3'h0;
        adc_valid_o = 1'b1;
        do @(posedge clk_i); while (!adc_ready_i);
        if (adc_ovr_o)
          w = adc_data_o[15] ? ppgt_pkg::NEG_FS : ppgt_pkg::POS_FS;
        else
          w = {1'b0, {5{adc_data_o[15]}}, adc_data_o, 2'b00};
        if (slot == 2'h0)
          exp0_q.push_back(w);
        if (slot == 2'h2)
          exp1_q.push_back(w);
        #2;
        adc_valid_o = 1'b0;
        // Released lines never keep the last value
        adc_data_o = ~adc_data_o;
        adc_ovr_o = !adc_ovr_o;
      end
    end
  end
endmodule

// >>> tb/ppgt_timing_tb.sv
// Self-checking bench of the pulse timing block
`timescale 1ns/1ns
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
  failures++; $display("Error t=%0t got %h exp %h", $time, g, e); end end
module ppgt_timing_tb;
  localparam int PER = 240 * 8;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic ref_clk_i = 1'b0;
  logic reg_page_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [31:0] reg_wdata_i = 32'h0;
  logic [31:0] reg_rdata_o, rnd = 32'hfdb2219e, cfg, e32;
  logic irq_o, hbridge_o, afe_pd_o, conv_start_o, adc_valid_i, adc_ready_o;
  logic adc_ovr_i, rd_q = 1'b0, drain = 1'b0;
  logic [1:0] led_on_o, conv_slot_o, smp_valid_o, smp_ready_i = 2'h0;
  logic [1:0] ext_thr_i = 2'h0, ext_full_i = 2'h0, ext_empty_i = 2'h0;
  logic [3:0] sample_hold_o, transimpedance_lowpass_setting_o;
  logic [2:0] led_cur_a_o, led_cur_b_o, amb_cancel_emit_o, amb_cancel_idle_o;
  logic [2:0] receive_gain_setting_o;
  logic [7:0] led_fine_a_o, led_fine_b_o;
  logic [15:0] adc_data_i;
  logic [1:0][23:0] smp_data_o;
  logic [23:0] e24;
  int failures = 0, samples_checked = 0;
  ppgt_timing ppgt_timing_i (.*);
  ppgt_adc_model ppgt_adc_model_i (.clk_i, .rst_b_i,
    .conv_start_i(conv_start_o), .conv_slot_i(conv_slot_o), .rnd_i(rnd),
    .adc_valid_o(adc_valid_i), .adc_ready_i(adc_ready_o),
    .adc_data_o(adc_data_i), .adc_ovr_o(adc_ovr_i));
  // ****
  // Clocks, random source, monitor
  // ****
  always #25 clk_i = ~clk_i;
  initial
  begin
    #37;
    forever #200 ref_clk_i = ~ref_clk_i;
  end
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  function automatic logic [2:0] cap(input logic [2:0] v, input logic [2:0] m);
    return v > m ? m : v;
  endfunction
  always @(posedge clk_i) rnd <= xs(rnd);
  always @(posedge clk_i) if (drain) smp_ready_i <= #2 rnd[5:4];
  logic [31:0] rexp_q[$];
  always @(posedge clk_i)
  begin
    if (rd_q)
    begin
      e32 = rexp_q.pop_front();
      `CHK(reg_rdata_o, e32)
    end
    rd_q <= reg_rd_i;
    if (smp_valid_o[0] && smp_ready_i[0])
    begin
      e24 = ppgt_adc_model_i.exp0_q.pop_front();
      `CHK(smp_data_o[0], e24)
    end
    if (smp_valid_o[1] && smp_ready_i[1])
    begin
      e24 = ppgt_adc_model_i.exp1_q.pop_front();
      `CHK(smp_data_o[1], e24)
    end
  end
  // ****
  // Register port tasks
  // ****
  task automatic acc(input logic pg, input logic [7:0] a, input logic w,
    input logic [31:0] d);
    @(posedge clk_i);
    #2;
    reg_page_i = pg;
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = w;
    reg_rd_i = !w;
    @(posedge clk_i);
    #2;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
  endtask
  task automatic wr(input logic pg, input logic [7:0] a, input logic [31:0] d);
    acc(pg, a, 1'b1, d);
  endtask
  task automatic rd(input logic pg, input logic [7:0] a, input logic [31:0] e);
    rexp_q.push_back(e);
    acc(pg, a, 1'b0, 32'h0);
  endtask
  task automatic settle;
    repeat (2) @(posedge clk_i);
    #2;
  endtask
  task automatic stop_test;
    $display("failures=%0d samples_checked=%0d", failures, samples_checked);
    if (failures == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    repeat (60000) @(posedge clk_i);
    failures++;
    stop_test;
  end
  // ****
  // Scenarios
  // ****
  initial
  begin
    repeat (3) @(posedge clk_i);
    #2;
    rst_b_i = 1'b1;
    `CHK(hbridge_o, 1'b0)
    rd(1'b0, ppgt_pkg::OFF_IRQ_EN, 32'h0);
    rd(1'b1, ppgt_pkg::OFF_TC10, ppgt_pkg::RST_TC10);
    rd(1'b1, ppgt_pkg::OFF_TC11, ppgt_pkg::RST_TC11);
    rd(1'b1, ppgt_pkg::OFF_TC12, ppgt_pkg::RST_TC12);
    rd(1'b1, 8'h00, 32'h0);
    cfg = rnd;
    wr(1'b1, ppgt_pkg::OFF_TC13, cfg);
    settle;
    `CHK({led_cur_b_o, led_cur_a_o}, {cfg[6:4], cfg[2:0]})
    `CHK({led_fine_b_o, led_fine_a_o}, cfg[23:8])
    for (int g = 0; g < 8; g++)
    begin
      wr(1'b1, ppgt_pkg::OFF_TC14, {25'h0, 3'(7 - g), 1'b0, 3'(g)});
      wr(1'b1, ppgt_pkg::OFF_TC15, {21'h0, 3'(g), 4'h0, 4'(g + 8)});
      settle;
      `CHK(amb_cancel_emit_o, cap(3'(g), ppgt_pkg::AMB_MAX))
      `CHK(amb_cancel_idle_o, cap(3'(7 - g), ppgt_pkg::AMB_MAX))
      `CHK(receive_gain_setting_o, cap(3'(g), ppgt_pkg::GAIN_MAX))
      `CHK(transimpedance_lowpass_setting_o, 4'(g + 8))
    end
    // Pin i: kind i/2 (threshold, full, empty), buffer 3*(i%2)
    for (int i = 0; i < 6; i++)
    begin
      {ext_empty_i, ext_full_i, ext_thr_i} = 6'h1 << i;
      settle;
      {ext_empty_i, ext_full_i, ext_thr_i} = 6'h0;
      cfg = 32'h1 << (9 * (i % 2) + i / 2);
      rd(1'b0, ppgt_pkg::OFF_IRQ_STAT, 32'h120 | cfg);
      wr(1'b0, ppgt_pkg::OFF_IRQ_STAT, cfg);
    end
    ext_thr_i = 2'h1;
    settle;
    ext_thr_i = 2'h0;
    `CHK(irq_o, 1'b0)
    wr(1'b0, ppgt_pkg::OFF_IRQ_EN, 32'h1);
    settle;
    `CHK(irq_o, 1'b1)
    wr(1'b0, ppgt_pkg::OFF_IRQ_STAT, 32'h1);
    settle;
    `CHK(irq_o, 1'b0)
    wr(1'b0, ppgt_pkg::OFF_IRQ_EN, 32'hfffff020);
    settle;
    `CHK(irq_o, 1'b1)
    rd(1'b0, ppgt_pkg::OFF_IRQ_EN, 32'h020);
    wr(1'b1, ppgt_pkg::OFF_TC16, 32'h1010);
    wr(1'b1, ppgt_pkg::OFF_TC11, 32'd55);
    wr(1'b1, ppgt_pkg::OFF_TC10, {2'h0, 14'd239, 13'h0, 3'h7});
    settle;
    `CHK(hbridge_o, 1'b1)
    // Fill both buffers, stop before a result would wait past a start
    while (ppgt_adc_model_i.exp1_q.size() < ppgt_pkg::FIFO_DEPTH)
      @(posedge clk_i);
    // Stop after the last slot so a restart keeps the order
    @(posedge clk_i iff (conv_start_o && conv_slot_o == 2'h3));
    wr(1'b1, ppgt_pkg::OFF_TC10, {2'h0, 14'd239, 13'h0, 3'h6});
    wr(1'b0, ppgt_pkg::OFF_IRQ_STAT, 32'hfff);
    rd(1'b0, ppgt_pkg::OFF_IRQ_STAT, 32'h0d8);
    drain = 1'b1;
    repeat (200) @(posedge clk_i);
    `CHK(ppgt_adc_model_i.exp0_q.size(), 0)
    `CHK(ppgt_adc_model_i.exp1_q.size(), 0)
    wr(1'b1, ppgt_pkg::OFF_TC10, {2'h0, 14'd239, 13'h0, 3'h7});
    @(posedge clk_i iff led_on_o[0]);
    cfg = 32'h0;
    repeat (PER) @(posedge clk_i) cfg += 32'(led_on_o[0]);
    `CHK(cfg, 32'(55 * 8))
    repeat (PER) @(posedge clk_i);
    stop_test;
  end
endmodule
